// ### logic/zsc_master_end.sv
// bus master end with its command fifo
`include "zsc_defines.svh"
`default_nettype none

module zsc_fifo #(
    parameter int WIDTH = `ZSC_CMD_W,
    parameter int DEPTH = `ZSC_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [PW:0] count;
    } zsc_fifo_state_type;

    zsc_fifo_state_type st;
    zsc_fifo_state_type next_st;
    logic push;
    logic pop;

    assign in_ready = st.count != (PW+1)'(DEPTH);
    assign out_valid = st.count != '0;
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == PW'(DEPTH-1)) ? '0 : PW'(st.wr + 1'b1);
        end
        if (pop) begin
            next_st.rd = (st.rd == PW'(DEPTH-1)) ? '0 : PW'(st.rd + 1'b1);
        end
        next_st.count = (PW+1)'(st.count + push - pop);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : zsc_fifo

module zsc_master_end (
    input wire logic clk,
    input wire logic rstn,
    zsc_if.host pins,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire zsc_pkg::zsc_addr_type cmd_addr,
    input wire zsc_pkg::zsc_data_type cmd_data,
    input wire logic user_hold,
    output logic rd_valid,
    output zsc_pkg::zsc_data_type rd_data
);

    zsc_pkg::zsc_host_state_type st;
    zsc_pkg::zsc_host_state_type next_st;
    zsc_pkg::zsc_cmd_type in_cmd;
    zsc_pkg::zsc_cmd_type head;
    logic head_valid;

    assign in_cmd = '{write: cmd_write, addr: cmd_addr, data: cmd_data};

    // commands queue here; a held bus stalls the pop and fills it
    zsc_fifo #(.WIDTH(`ZSC_CMD_W), .DEPTH(`ZSC_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(in_cmd),
        .out_valid(head_valid),
        .out_ready(!user_hold),
        .out_data(head)
    );

    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        if (!st.clock_suspend_n) begin
            // enabled edge: close the data phase, open the next one
            if (st.dat_valid && !st.dat_write) begin
                next_st.rd_valid = 1'b1;
                next_st.rd_data = pins.dq_bus;
            end
            next_st.dat_valid = !st.advance_or_load && !st.chip_select_low_a
                && st.chip_select_high && !st.chip_select_low_b;
            next_st.dat_write = !st.read_not_write;
            next_st.dat_data = st.load_data;
        end
        if (user_hold) begin
            next_st.clock_suspend_n = 1'b1;
        end else begin
            next_st.clock_suspend_n = 1'b0;
            next_st.advance_or_load = 1'b0;
            if (head_valid) begin
                next_st.chip_select_low_a = 1'b0;
                next_st.chip_select_high = 1'b1;
                next_st.chip_select_low_b = 1'b0;
                next_st.addr = head.addr;
                next_st.read_not_write = !head.write;
                next_st.byte_write_strobe_n = head.write ?
                    `ZSC_STRB_ALL : `ZSC_STRB_IDLE;
                next_st.load_data = head.data;
            end else begin
                next_st.chip_select_low_a = 1'b1;
                next_st.chip_select_high = 1'b0;
                next_st.chip_select_low_b = 1'b1;
            end
        end
        // write data phase keeps strobes low with the data
        if (next_st.dat_valid && next_st.dat_write) begin
            next_st.byte_write_strobe_n = `ZSC_STRB_ALL;
        end
        next_st.output_drive_enable_n =
            !(next_st.dat_valid && !next_st.dat_write);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.chip_select_low_a <= 1'b1;
            st.chip_select_low_b <= 1'b1;
            st.read_not_write <= 1'b1;
            st.byte_write_strobe_n <= `ZSC_STRB_IDLE;
            st.output_drive_enable_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign pins.addr = st.addr;
    assign pins.read_not_write = st.read_not_write;
    assign pins.advance_or_load = st.advance_or_load;
    assign pins.chip_select_low_a = st.chip_select_low_a;
    assign pins.chip_select_high = st.chip_select_high;
    assign pins.chip_select_low_b = st.chip_select_low_b;
    assign pins.clock_suspend_n = st.clock_suspend_n;
    assign pins.byte_write_strobe_n = st.byte_write_strobe_n;
    assign pins.output_drive_enable_n = st.output_drive_enable_n;
    assign pins.dq_host = st.dat_data;
    assign pins.dq_host_oe = st.dat_valid && st.dat_write;
    assign rd_valid = st.rd_valid;
    assign rd_data = st.rd_data;

endmodule : zsc_master_end

`default_nettype wire

// ### logic/zsc_defines.svh
// constants of the zero-turnaround sram cycle control
`ifndef ZSC_DEFINES_SVH
`define ZSC_DEFINES_SVH

`define ZSC_ADDR_W 17
`define ZSC_DATA_W 36
`define ZSC_LANES 4
`define ZSC_LANE_W 9
`define ZSC_BEAT_W 2
`define ZSC_MEM_AW 6
`define ZSC_MEM_WORDS 64
`define ZSC_FIFO_DEPTH 8
`define ZSC_CMD_W 54
`define ZSC_DATA_RST 36'h0_0000_0000
`define ZSC_ADDR_RST 17'h0_0000
`define ZSC_STRB_IDLE 4'hF
`define ZSC_STRB_ALL 4'h0

`endif

// ### logic/zsc_pkg.sv
// types shared by both ends of the sram cycle control
`include "zsc_defines.svh"
`default_nettype none

package zsc_pkg;

    typedef logic [`ZSC_ADDR_W-1:0] zsc_addr_type;
    typedef logic [`ZSC_DATA_W-1:0] zsc_data_type;
    typedef logic [`ZSC_LANES-1:0] zsc_strb_type;
    typedef logic [`ZSC_BEAT_W-1:0] zsc_beat_type;
    typedef logic [`ZSC_MEM_AW-1:0] zsc_index_type;

    typedef struct packed {
        logic write;
        zsc_addr_type addr;
        zsc_data_type data;
    } zsc_cmd_type;

    typedef struct packed {
        logic [`ZSC_MEM_WORDS-1:0][`ZSC_DATA_W-1:0] mem;
        logic pend_valid;
        logic pend_write;
        zsc_addr_type pend_addr;
        zsc_addr_type base;
        zsc_beat_type beat;
        logic burst_ok;
        zsc_data_type dout;
        logic dout_oe;
        logic taken;
        logic written;
    } zsc_dev_state_type;

    typedef struct packed {
        zsc_addr_type addr;
        logic read_not_write;
        logic advance_or_load;
        logic chip_select_low_a;
        logic chip_select_high;
        logic chip_select_low_b;
        logic clock_suspend_n;
        zsc_strb_type byte_write_strobe_n;
        logic output_drive_enable_n;
        zsc_data_type load_data;
        logic dat_valid;
        logic dat_write;
        zsc_data_type dat_data;
        logic rd_valid;
        zsc_data_type rd_data;
    } zsc_host_state_type;

endpackage : zsc_pkg

`default_nettype wire

// ### logic/zsc_if.sv
// pin bundle between the bus master and the sram end
`include "zsc_defines.svh"
`default_nettype none

interface zsc_if (
    input wire logic clk,
    input wire logic rstn
);
    zsc_pkg::zsc_addr_type addr;
    logic read_not_write;
    logic advance_or_load;
    logic chip_select_low_a;
    logic chip_select_high;
    logic chip_select_low_b;
    logic clock_suspend_n;
    zsc_pkg::zsc_strb_type byte_write_strobe_n;
    logic output_drive_enable_n;
    zsc_pkg::zsc_data_type dq_host;
    logic dq_host_oe;
    zsc_pkg::zsc_data_type dq_dev;
    logic dq_dev_oe;
    zsc_pkg::zsc_data_type dq_bus;
    logic dq_driven;

    // shared data wire: the sram drives only while its async enable is low
    assign dq_driven = (dq_dev_oe && !output_drive_enable_n) || dq_host_oe;
    assign dq_bus = (dq_dev_oe && !output_drive_enable_n) ? dq_dev :
                    (dq_host_oe ? dq_host : `ZSC_DATA_RST);

    modport dev (
        input addr, read_not_write, advance_or_load, chip_select_low_a,
        input chip_select_high, chip_select_low_b, clock_suspend_n,
        input byte_write_strobe_n, output_drive_enable_n, dq_bus,
        output dq_dev, dq_dev_oe
    );

    modport host (
        output addr, read_not_write, advance_or_load, chip_select_low_a,
        output chip_select_high, chip_select_low_b, clock_suspend_n,
        output byte_write_strobe_n, output_drive_enable_n,
        output dq_host, dq_host_oe,
        input dq_bus
    );
endinterface : zsc_if

`default_nettype wire

// ### logic/zsc_sram_end.sv
// sram end: registered control, burst counter, flop storage
`include "zsc_defines.svh"
`default_nettype none

module zsc_sram_end (
    input wire logic clk,
    input wire logic rstn,
    zsc_if.dev pins,
    output logic op_taken,
    output logic data_written,
    output logic burst_ok,
    output zsc_pkg::zsc_beat_type burst_beat
);

    zsc_pkg::zsc_dev_state_type st;
    zsc_pkg::zsc_dev_state_type next_st;
    logic selected;

    // three selects, one of them active high
    function automatic logic sel_fn(
        input logic low_a,
        input logic high,
        input logic low_b
    );
        sel_fn = !low_a && high && !low_b;
    endfunction : sel_fn

    // storage index from address
    function automatic zsc_pkg::zsc_index_type idx_fn(
        input zsc_pkg::zsc_addr_type a
    );
        idx_fn = a[`ZSC_MEM_AW-1:0];
    endfunction : idx_fn

    // linear burst address within the four word group
    function automatic zsc_pkg::zsc_addr_type burst_fn(
        input zsc_pkg::zsc_addr_type base,
        input zsc_pkg::zsc_beat_type beat
    );
        zsc_pkg::zsc_beat_type low;
        low = zsc_pkg::zsc_beat_type'(base[`ZSC_BEAT_W-1:0] + beat);
        burst_fn = {base[`ZSC_ADDR_W-1:`ZSC_BEAT_W], low};
    endfunction : burst_fn

    // byte lane merge, strobes active low
    function automatic zsc_pkg::zsc_data_type merge_fn(
        input zsc_pkg::zsc_data_type old_word,
        input zsc_pkg::zsc_data_type new_word,
        input zsc_pkg::zsc_strb_type strb_n
    );
        merge_fn = old_word;
        for (int i = 0; i < `ZSC_LANES; i++) begin
            if (!strb_n[i]) begin
                merge_fn[i*`ZSC_LANE_W +: `ZSC_LANE_W] =
                    new_word[i*`ZSC_LANE_W +: `ZSC_LANE_W];
            end
        end
    endfunction : merge_fn

    assign selected = sel_fn(pins.chip_select_low_a, pins.chip_select_high,
                             pins.chip_select_low_b);

    always_comb begin
        next_st = st;
        next_st.taken = 1'b0;
        next_st.written = 1'b0;
        if (!pins.clock_suspend_n) begin
            // data phase of the access loaded on the previous enabled edge
            if (st.pend_valid && st.pend_write) begin
                next_st.mem[idx_fn(st.pend_addr)] = merge_fn(
                    st.mem[idx_fn(st.pend_addr)], pins.dq_bus,
                    pins.byte_write_strobe_n);
                next_st.written = 1'b1;
            end
            // address and control phase
            if (!pins.advance_or_load) begin
                if (selected) begin
                    next_st.pend_valid = 1'b1;
                    next_st.pend_write = !pins.read_not_write;
                    next_st.pend_addr = pins.addr;
                    next_st.base = pins.addr;
                    next_st.beat = '0;
                    next_st.burst_ok = 1'b1;
                    next_st.taken = 1'b1;
                end else begin
                    // deselect stops any burst, pending one still finishes
                    next_st.pend_valid = 1'b0;
                    next_st.burst_ok = 1'b0;
                end
            end else if (st.burst_ok) begin
                next_st.beat = zsc_pkg::zsc_beat_type'(st.beat + 1'b1);
                next_st.pend_addr = burst_fn(st.base, next_st.beat);
                next_st.pend_valid = 1'b1;
            end else begin
                next_st.pend_valid = 1'b0;
            end
            // flow-through read word, newest write already merged in
            next_st.dout_oe = next_st.pend_valid && !next_st.pend_write;
            next_st.dout = next_st.mem[idx_fn(next_st.pend_addr)];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st.mem <= '0;
            st.pend_valid <= 1'b0;
            st.pend_write <= 1'b0;
            st.pend_addr <= `ZSC_ADDR_RST;
            st.base <= `ZSC_ADDR_RST;
            st.beat <= '0;
            st.burst_ok <= 1'b0;
            st.dout <= `ZSC_DATA_RST;
            st.dout_oe <= 1'b0;
            st.taken <= 1'b0;
            st.written <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // the interface gates this with the async drive enable
    assign pins.dq_dev = st.dout;
    assign pins.dq_dev_oe = st.dout_oe;
    assign op_taken = st.taken;
    assign data_written = st.written;
    assign burst_ok = st.burst_ok;
    assign burst_beat = st.beat;

endmodule : zsc_sram_end

`default_nettype wire

// ### testbench/zsc_properties.sv
// pin bundle assertions for the sram cycle control
`include "zsc_defines.svh"
`default_nettype none

module zsc_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic read_not_write,
    input wire logic advance_or_load,
    input wire logic chip_select_low_a,
    input wire logic chip_select_high,
    input wire logic chip_select_low_b,
    input wire logic clock_suspend_n,
    input wire zsc_pkg::zsc_strb_type byte_write_strobe_n,
    input wire logic output_drive_enable_n,
    input wire zsc_pkg::zsc_data_type dq_host,
    input wire logic dq_host_oe,
    input wire zsc_pkg::zsc_data_type dq_dev,
    input wire logic dq_dev_oe
);
    wire logic sel;
    wire logic en;
    wire logic ld;
    assign sel = !chip_select_low_a && chip_select_high && !chip_select_low_b;
    assign en = !clock_suspend_n;
    assign ld = en && !advance_or_load && sel;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_rd_load;
        ld && read_not_write;
    endsequence
    sequence s_rd_data;
        dq_dev_oe && !output_drive_enable_n;
    endsequence
    sequence s_wr_load;
        ld && !read_not_write;
    endsequence

    a_read_next: assert property (s_rd_load |=> s_rd_data)
        else $error("read data missing after load");
    a_suspend_hold: assert property (
        !en && dq_dev_oe |=> dq_dev_oe && $stable(dq_dev))
        else $error("read data moved on suspended edge");
    a_idle_off: assert property (
        en && !advance_or_load && !(sel && read_not_write) |=> !dq_dev_oe)
        else $error("sram drives data without a read");
    a_desel_read: assert property (s_rd_load ##1 !sel |-> s_rd_data)
        else $error("pending read lost on deselect");
    a_power_quiet: assert property (
        $rose(rstn) |-> !dq_dev_oe && !dq_host_oe)
        else $error("data driven right after reset");
    a_no_clash: assert property (
        !(dq_host_oe && dq_dev_oe && !output_drive_enable_n))
        else $error("both ends drive data");
    a_write_data: assert property (s_wr_load |=> dq_host_oe)
        else $error("write data missing after load");
    a_write_hold: assert property (
        dq_host_oe && !en |=> dq_host_oe && $stable(dq_host))
        else $error("write data moved on suspended edge");
    a_write_lanes: assert property (
        s_wr_load |-> byte_write_strobe_n == `ZSC_STRB_ALL)
        else $error("write load without all strobes");
endmodule : zsc_properties

`default_nettype wire

// ### testbench/zero_turnaround_sram_cycle_control_tb.sv
// bench joining master end and sram end
`include "zsc_defines.svh"
`default_nettype none

module zero_turnaround_sram_cycle_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic w;
        zsc_pkg::zsc_addr_type a;
        zsc_pkg::zsc_data_type d;
    } zsc_row_type;

    // read rows carry the word they should return
    zsc_row_type rows [9] = '{
        '{1'b1, 17'h0_0005, 36'h1_1111_1111},
        '{1'b1, 17'h1_003F, 36'h2_AAAA_AAAA},
        '{1'b0, 17'h0_0005, 36'h1_1111_1111},
        '{1'b1, 17'h0_0005, 36'h3_C3C3_C3C3},
        '{1'b0, 17'h0_0005, 36'h3_C3C3_C3C3},
        '{1'b0, 17'h0_003F, 36'h2_AAAA_AAAA},
        '{1'b0, 17'h0_0000, 36'h0_0000_0000},
        '{1'b1, 17'h1_FFFF, 36'hF_FFFF_FFFF},
        '{1'b0, 17'h0_003F, 36'hF_FFFF_FFFF}
    };

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    zsc_pkg::zsc_addr_type cmd_addr = `ZSC_ADDR_RST;
    zsc_pkg::zsc_data_type cmd_data = `ZSC_DATA_RST;
    logic user_hold = 1'b0;
    logic cmd_ready;
    logic rd_valid;
    zsc_pkg::zsc_data_type rd_data;
    logic op_taken;
    logic data_written;
    logic burst_ok;
    zsc_pkg::zsc_beat_type burst_beat;
    int n_cmd = 0;
    int n_ld = 0;
    logic ok;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_wr = 0;
    int n_wr_seen = 0;
    zsc_pkg::zsc_data_type exp_q [$];
    zsc_pkg::zsc_data_type got_q [$];

    always #2.5 clk = ~clk;

    zsc_if bus (.clk(clk), .rstn(rstn));

    zsc_sram_end zsc_sram_end_inst (.clk(clk), .rstn(rstn), .pins(bus),
        .op_taken(op_taken), .data_written(data_written),
        .burst_ok(burst_ok), .burst_beat(burst_beat));

    zsc_master_end zsc_master_end_inst (.clk(clk), .rstn(rstn), .pins(bus),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .user_hold(user_hold), .rd_valid(rd_valid), .rd_data(rd_data));

    zsc_properties zsc_properties_inst (.clk(clk), .rstn(rstn),
        .read_not_write(bus.read_not_write),
        .advance_or_load(bus.advance_or_load),
        .chip_select_low_a(bus.chip_select_low_a),
        .chip_select_high(bus.chip_select_high),
        .chip_select_low_b(bus.chip_select_low_b),
        .clock_suspend_n(bus.clock_suspend_n),
        .byte_write_strobe_n(bus.byte_write_strobe_n),
        .output_drive_enable_n(bus.output_drive_enable_n),
        .dq_host(bus.dq_host), .dq_host_oe(bus.dq_host_oe),
        .dq_dev(bus.dq_dev), .dq_dev_oe(bus.dq_dev_oe));

    always @(posedge clk) begin
        if (rd_valid === 1'b1) got_q.push_back(rd_data);
        if (data_written === 1'b1) n_wr_seen++;
        if (op_taken === 1'b1) n_ld++;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk_data(input zsc_pkg::zsc_data_type g, e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t data %h want %h", $time, g, e);
        end
    endtask : chk_data

    task automatic chk_bit(input logic g, e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t flag %b want %b", $time, g, e);
        end
    endtask : chk_bit

    task automatic push(input logic w, input zsc_pkg::zsc_addr_type a,
                        input zsc_pkg::zsc_data_type d);
        int n;
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_data <= d;
        if (w) n_wr++;
        else exp_q.push_back(d);
        n_cmd++;
        n = 0;
        do begin
            @(negedge clk);
            ok = cmd_ready;
            @(posedge clk);
            n++;
        end while (ok !== 1'b1 && n < 100);
        if (ok !== 1'b1) begin
            bad_count++;
            $display("MISMATCH %0t command not accepted", $time);
        end
    endtask : push

    task automatic finish_test(input string name);
        int n;
        cmd_valid <= 1'b0;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 300) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        chk_bit(got_q.size() == exp_q.size(), 1'b1);
        foreach (exp_q[i]) begin
            if (i < got_q.size()) begin
                chk_data(got_q[i], exp_q[i]);
            end
        end
        chk_bit(n_wr_seen == n_wr, 1'b1);
        chk_bit(n_ld == n_cmd, 1'b1);
        chk_bit(burst_ok, 1'b0);
        chk_data(36'(burst_beat), `ZSC_DATA_RST);
        exp_q.delete();
        got_q.delete();
        $display("test %s done", name);
    endtask : finish_test

    task automatic reset_dut;
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk_bit(bus.dq_dev_oe, 1'b0);
        chk_bit(rd_valid, 1'b0);
        @(posedge clk);
        rstn <= 1'b1;
        n_wr = 0;
        n_wr_seen = 0;
        n_cmd = 0;
        n_ld = 0;
        @(posedge clk);
    endtask : reset_dut

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    initial begin
        reset_dut();
        foreach (rows[i]) push(rows[i].w, rows[i].a, rows[i].d);
        finish_test("table");
        user_hold <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            push(1'b1, 17'h0_0010 + 17'(i), 36'hA_0000_0000 + 36'(i));
            push(1'b0, 17'h0_0010 + 17'(i), 36'hA_0000_0000 + 36'(i));
        end
        cmd_valid <= 1'b0;
        @(negedge clk);
        chk_bit(cmd_ready, 1'b0);
        chk_bit(bus.clock_suspend_n, 1'b1);
        @(posedge clk);
        for (int i = 0; i < 40; i++) begin
            user_hold <= (i % 3 != 0);
            @(posedge clk);
        end
        user_hold <= 1'b0;
        finish_test("suspend");
        reset_dut();
        push(1'b0, 17'h0_0005, `ZSC_DATA_RST);
        finish_test("reset");
        end_of_test();
    end
endmodule : zero_turnaround_sram_cycle_control_tb

`default_nettype wire
